// ===== ccr_defines.svh
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
// Behaviour
// - Fast code samples telemetry about every 11ms; slow code may idle to 5s.
// - Always-on bit keeps telemetry running, even on battery power alone.
// - Tracking enable lets the tracker drive the active input droop code.
// - Equalization request starts or queues equalization once absorb ends.
// - Request self-clears on equalization timeout, charging pause or power cycle.
// - Host writing zero to the request cancels pending or running equalization.
// - Input current cap, command 15h, six bits, default 63, read/write.
// - Droop level, command 16h, eight bits, default 31, ignored while tracking.
// - Key 21325 in command 19h arms storage mode below about 1V input.
// - Battery current code, command 1Ah, five bits, default 31.
// - Active current follows battery code unless thermal regulation lowers it.
// - Float voltage code, command 1Bh, six bits, default 21.
// - Active voltage follows float code unless temperature compensation alters it.
// - Signed taper threshold, command 1Ch, default 2184, ends absorb on taper.
// - Temperature compensation enable at 29h bit 1, default one.
// - Pause bit 5 of the configuration register suspends charging.
`define CCR_CMD_CONFIG 8'h14
`define CCR_CMD_IIN_CAP 8'h15
`define CCR_CMD_DROOP 8'h16
`define CCR_CMD_STORE_KEY 8'h19
`define CCR_CMD_BAT_CUR 8'h1A
`define CCR_CMD_FLOAT_V 8'h1B
`define CCR_CMD_TAPER 8'h1C
`define CCR_CMD_TEMP_COMP 8'h29
`define CCR_BIT_PAUSE 5
`define CCR_BIT_MEAS_FAST 3
`define CCR_BIT_MEAS_ON 2
`define CCR_BIT_PPT_EN 1
`define CCR_BIT_EQ_REQ 0
`define CCR_BIT_TC_EN 1
`define CCR_RST_IIN_CAP 6'h3F
`define CCR_RST_DROOP 8'h1F
`define CCR_RST_STORE_KEY 16'h0000
`define CCR_RST_BAT_CUR 5'h1F
`define CCR_RST_FLOAT_V 6'h15
`define CCR_RST_TAPER 16'h0888
`define CCR_RST_TC_EN 1'h1
`define CCR_STORE_KEY 16'h534D
`define CCR_DEV_ADDR 7'h2A
`define CCR_CLK_PERIOD_NS 64'h5
`define CCR_NS_PER_MS 64'hF4240
`define CCR_NS_PER_S 64'h3B9ACA00
`define CCR_FAST_PERIOD_MS 64'hB
`define CCR_SLOW_PERIOD_S 64'h5
`endif

// ===== ccr_pkg.sv
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_EQ_IDLE = 2'h0,
    CCR_EQ_PEND = 2'h1,
    CCR_EQ_RUN = 2'h3
  } ccr_eq_t;
  typedef enum logic [2:0] {
    CCR_BUS_IDLE = 3'h0,
    CCR_BUS_RX = 3'h1,
    CCR_BUS_ACK = 3'h3,
    CCR_BUS_TX = 3'h2,
    CCR_BUS_MACK = 3'h6
  } ccr_bus_t;
  typedef struct packed {
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    ccr_bus_t bus;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] shift, cmd, wr_lo;
    logic [15:0] tx_word;
    logic rd_sel, hi_phase, nack, sda_oe_n, sda_out;
    logic pause, meas_fast, meas_on, ppt_en, eq_req, tc_en;
    logic [5:0] iin_cap, float_v;
    logic [7:0] droop;
    logic [15:0] store_key, taper;
    logic [4:0] bat_cur;
    ccr_eq_t eq;
    logic [29:0] meas_cnt;
    logic meas_tick, tel_on, storage, taper_hit, eq_active, eq_pending;
    logic [5:0] iin_cap_act, volt_act;
    logic [7:0] droop_act;
    logic [4:0] cur_act;
  } ccr_state_t;
endpackage

// ===== ccr_config_bank.sv
`timescale 1ns/10ps
`include "ccr_defines.svh"
module ccr_config_bank #(
  parameter longint unsigned FAST_CYCLES =
    `CCR_FAST_PERIOD_MS * `CCR_NS_PER_MS / `CCR_CLK_PERIOD_NS,
  parameter longint unsigned SLOW_CYCLES =
    `CCR_SLOW_PERIOD_S * `CCR_NS_PER_S / `CCR_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Two-wire serial port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Charger core status
  input wire logic charging,
  input wire logic input_present,
  input wire logic in_absorb,
  input wire logic absorb_timer_done,
  input wire logic equalize_timer_done,
  input wire logic [15:0] ibat_reading,
  input wire logic thermal_reg_active,
  input wire logic [4:0] thermal_cap_code,
  input wire logic [5:0] temp_comp_code,
  input wire logic [7:0] ppt_droop_code,
  input wire logic vin_below_1v,
  // Active set-points
  output logic [5:0] iin_cap_active,
  output logic [7:0] droop_active,
  output logic [4:0] charge_current_active,
  output logic [5:0] charge_voltage_active,
  // Control and status
  output logic meas_tick,
  output logic telemetry_on,
  output logic meas_fast,
  output logic equalize_active,
  output logic equalize_pending,
  output logic storage_mode,
  output logic charge_paused,
  output logic taper_detect
);
  import ccr_pkg::*;

  localparam logic [29:0] FAST_M1 = 30'(FAST_CYCLES - 64'h1);
  localparam logic [29:0] SLOW_M1 = 30'(SLOW_CYCLES - 64'h1);

  ccr_state_t st;
  ccr_state_t next_st;
  logic scl_rise, scl_fall, bus_start, bus_stop, wr_go, cfg_wr, absorb_end;
  logic [7:0] wr_cmd;
  logic [15:0] wr_data, rd_word;
  logic [29:0] period_m1;

  // Register read decode
  function automatic logic [15:0] reg_read(input ccr_state_t s, input logic [7:0] c);
    reg_read = 16'h0000;
    case (c)
      `CCR_CMD_CONFIG: reg_read = {10'h000, s.pause, 1'h0, s.meas_fast, s.meas_on,
                                   s.ppt_en, s.eq_req};
      `CCR_CMD_IIN_CAP: reg_read = {10'h000, s.iin_cap};
      `CCR_CMD_DROOP: reg_read = {8'h00, s.droop};
      `CCR_CMD_STORE_KEY: reg_read = s.store_key;
      `CCR_CMD_BAT_CUR: reg_read = {11'h000, s.bat_cur};
      `CCR_CMD_FLOAT_V: reg_read = {10'h000, s.float_v};
      `CCR_CMD_TAPER: reg_read = s.taper;
      `CCR_CMD_TEMP_COMP: reg_read = {14'h0000, s.tc_en, 1'h0};
      default: reg_read = 16'h0000;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d = st.scl_s2;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d = st.sda_s2;
    next_st.sda_out = 1'h0;
    scl_rise = st.scl_s2 & ~st.scl_d;
    scl_fall = ~st.scl_s2 & st.scl_d;
    bus_start = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
    bus_stop = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;
    wr_go = 1'h0;
    wr_cmd = st.cmd;
    wr_data = {st.shift, st.wr_lo};
    rd_word = reg_read(st, st.cmd);

    // Serial slave: word writes and reads, low byte first
    if (bus_start) begin
      next_st.bus = CCR_BUS_RX;
      next_st.bit_cnt = 4'h0;
      next_st.byte_idx = 2'h0;
      next_st.sda_oe_n = 1'h1;
    end else if (bus_stop) begin
      next_st.bus = CCR_BUS_IDLE;
      next_st.sda_oe_n = 1'h1;
    end else begin
      case (st.bus)
        CCR_BUS_RX: begin
          if (scl_rise && st.bit_cnt != 4'h8) begin
            next_st.shift = {st.shift[6:0], st.sda_s2};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall && st.bit_cnt == 4'h8) begin
            next_st.bus = CCR_BUS_ACK;
            next_st.sda_oe_n = 1'h0;
            case (st.byte_idx)
              2'h0: begin
                next_st.rd_sel = st.shift[0];
                if (st.shift[7:1] != `CCR_DEV_ADDR) begin
                  next_st.bus = CCR_BUS_IDLE;
                  next_st.sda_oe_n = 1'h1;
                end
              end
              2'h1: next_st.cmd = st.shift;
              2'h2: next_st.wr_lo = st.shift;
              default: wr_go = 1'h1;
            endcase
          end
        end
        CCR_BUS_ACK: begin
          if (scl_fall) begin
            next_st.sda_oe_n = 1'h1;
            next_st.bit_cnt = 4'h0;
            if (st.rd_sel && st.byte_idx == 2'h0) begin
              next_st.tx_word = rd_word;
              next_st.shift = rd_word[7:0];
              next_st.sda_oe_n = rd_word[7];
              next_st.hi_phase = 1'h0;
              next_st.bus = CCR_BUS_TX;
            end else if (st.byte_idx == 2'h3) begin
              next_st.bus = CCR_BUS_IDLE;
            end else begin
              next_st.byte_idx = st.byte_idx + 2'h1;
              next_st.bus = CCR_BUS_RX;
            end
          end
        end
        CCR_BUS_TX: begin
          if (scl_fall) begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            next_st.shift = {st.shift[6:0], 1'h0};
            next_st.sda_oe_n = st.shift[6];
            if (st.bit_cnt == 4'h7) begin
              next_st.sda_oe_n = 1'h1;
              next_st.bus = CCR_BUS_MACK;
            end
          end
        end
        CCR_BUS_MACK: begin
          if (scl_rise) begin
            next_st.nack = st.sda_s2;
          end else if (scl_fall) begin
            if (!st.nack && !st.hi_phase) begin
              next_st.shift = st.tx_word[15:8];
              next_st.sda_oe_n = st.tx_word[15];
              next_st.bit_cnt = 4'h0;
              next_st.hi_phase = 1'h1;
              next_st.bus = CCR_BUS_TX;
            end else begin
              next_st.bus = CCR_BUS_IDLE;
            end
          end
        end
        default: begin
          next_st.bus = CCR_BUS_IDLE;
          next_st.sda_oe_n = 1'h1;
        end
      endcase
    end

    // Register writes; undocumented bits are dropped
    cfg_wr = wr_go && wr_cmd == `CCR_CMD_CONFIG;
    if (wr_go) begin
      case (wr_cmd)
        `CCR_CMD_CONFIG: begin
          next_st.pause = wr_data[`CCR_BIT_PAUSE];
          next_st.meas_fast = wr_data[`CCR_BIT_MEAS_FAST];
          next_st.meas_on = wr_data[`CCR_BIT_MEAS_ON];
          next_st.ppt_en = wr_data[`CCR_BIT_PPT_EN];
        end
        `CCR_CMD_IIN_CAP: next_st.iin_cap = wr_data[5:0];
        `CCR_CMD_DROOP: next_st.droop = wr_data[7:0];
        `CCR_CMD_STORE_KEY: next_st.store_key = wr_data;
        `CCR_CMD_BAT_CUR: next_st.bat_cur = wr_data[4:0];
        `CCR_CMD_FLOAT_V: next_st.float_v = wr_data[5:0];
        `CCR_CMD_TAPER: next_st.taper = wr_data;
        `CCR_CMD_TEMP_COMP: next_st.tc_en = wr_data[`CCR_BIT_TC_EN];
        default: next_st.cmd = st.cmd;
      endcase
    end

    // Equalization request and phase; a host write wins over a self-clear
    next_st.taper_hit = $signed(ibat_reading) < $signed(st.taper);
    absorb_end = in_absorb && (absorb_timer_done || next_st.taper_hit);
    if ((st.eq == CCR_EQ_RUN && equalize_timer_done) || st.pause) begin
      next_st.eq_req = 1'h0;
    end
    if (cfg_wr) begin
      next_st.eq_req = wr_data[`CCR_BIT_EQ_REQ];
    end
    if (!next_st.eq_req) begin
      next_st.eq = CCR_EQ_IDLE;
    end else begin
      case (st.eq)
        CCR_EQ_IDLE: next_st.eq = absorb_end ? CCR_EQ_RUN : CCR_EQ_PEND;
        CCR_EQ_PEND: next_st.eq = absorb_end ? CCR_EQ_RUN : CCR_EQ_PEND;
        CCR_EQ_RUN: next_st.eq = CCR_EQ_RUN;
        default: next_st.eq = CCR_EQ_IDLE;
      endcase
    end
    next_st.eq_active = next_st.eq == CCR_EQ_RUN;
    next_st.eq_pending = next_st.eq == CCR_EQ_PEND;

    // Storage mode latches once armed and the input is low
    next_st.storage = (st.store_key == `CCR_STORE_KEY) && (st.storage || vin_below_1v);

    // Telemetry sampling tick
    next_st.tel_on = st.meas_on || input_present;
    period_m1 = (st.meas_fast || charging) ? FAST_M1 : SLOW_M1;
    next_st.meas_tick = 1'h0;
    if (!st.tel_on) begin
      next_st.meas_cnt = 30'h0;
    end else if (st.meas_cnt >= period_m1) begin
      next_st.meas_cnt = 30'h0;
      next_st.meas_tick = 1'h1;
    end else begin
      next_st.meas_cnt = st.meas_cnt + 30'h1;
    end

    // Active set-points toward the regulation loops
    next_st.iin_cap_act = st.iin_cap;
    next_st.droop_act = st.ppt_en ? ppt_droop_code : st.droop;
    next_st.cur_act = (thermal_reg_active && thermal_cap_code < st.bat_cur) ?
                      thermal_cap_code : st.bat_cur;
    next_st.volt_act = st.tc_en ? temp_comp_code : st.float_v;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st <= '0;
      st.scl_s1 <= 1'h1;
      st.scl_s2 <= 1'h1;
      st.scl_d <= 1'h1;
      st.sda_s1 <= 1'h1;
      st.sda_s2 <= 1'h1;
      st.sda_d <= 1'h1;
      st.bus <= CCR_BUS_IDLE;
      st.eq <= CCR_EQ_IDLE;
      st.sda_oe_n <= 1'h1;
      st.nack <= 1'h1;
      st.iin_cap <= `CCR_RST_IIN_CAP;
      st.droop <= `CCR_RST_DROOP;
      st.store_key <= `CCR_RST_STORE_KEY;
      st.bat_cur <= `CCR_RST_BAT_CUR;
      st.float_v <= `CCR_RST_FLOAT_V;
      st.taper <= `CCR_RST_TAPER;
      st.tc_en <= `CCR_RST_TC_EN;
      st.iin_cap_act <= `CCR_RST_IIN_CAP;
      st.droop_act <= `CCR_RST_DROOP;
      st.cur_act <= `CCR_RST_BAT_CUR;
      st.volt_act <= `CCR_RST_FLOAT_V;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out = st.sda_out;
  assign sda_oe_n = st.sda_oe_n;
  assign iin_cap_active = st.iin_cap_act;
  assign droop_active = st.droop_act;
  assign charge_current_active = st.cur_act;
  assign charge_voltage_active = st.volt_act;
  assign meas_tick = st.meas_tick;
  assign telemetry_on = st.tel_on;
  assign meas_fast = st.meas_fast;
  assign equalize_active = st.eq_active;
  assign equalize_pending = st.eq_pending;
  assign storage_mode = st.storage;
  assign charge_paused = st.pause;
  assign taper_detect = st.taper_hit;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence absorb_finish_s;
    st.eq == CCR_EQ_PEND && in_absorb && absorb_timer_done;
  endsequence
  sequence host_cancel_s;
    wr_go && wr_cmd == `CCR_CMD_CONFIG && !wr_data[`CCR_BIT_EQ_REQ];
  endsequence
  sequence cap_write_s;
    wr_go && wr_cmd == `CCR_CMD_IIN_CAP;
  endsequence

  AST_MEAS_RATE: assert property (meas_tick |-> $past(st.meas_cnt) >= FAST_M1)
    else $error("measurement tick came early");
  AST_MEAS_OFF: assert property (!st.tel_on |=> !meas_tick)
    else $error("tick while telemetry off");
  AST_DROOP_SEL: assert property (1'h1 |=> droop_active ==
      ($past(st.ppt_en) ? $past(ppt_droop_code) : $past(st.droop)))
    else $error("droop code source wrong");
  AST_EQ_START: assert property (absorb_finish_s |=> equalize_active || !st.eq_req)
    else $error("equalization did not start after absorb");
  AST_EQ_DONE: assert property (st.eq == CCR_EQ_RUN && equalize_timer_done && !cfg_wr
      |=> !st.eq_req ##1 !equalize_active)
    else $error("request not cleared at equalization timeout");
  AST_EQ_CANCEL: assert property (host_cancel_s |=> !equalize_active && !equalize_pending)
    else $error("host cancel ignored");
  AST_CAP_RB: assert property (cap_write_s |=> st.iin_cap == $past(wr_data[5:0])
      ##1 iin_cap_active == $past(st.iin_cap))
    else $error("current cap write not taken");
  AST_STORE: assert property (st.store_key == `CCR_STORE_KEY && vin_below_1v
      |=> storage_mode)
    else $error("storage mode not entered");
  AST_CUR_ACT: assert property (1'h1 |=> charge_current_active <= $past(st.bat_cur) &&
      ($past(thermal_reg_active) || charge_current_active == $past(st.bat_cur)))
    else $error("active current code wrong");
  AST_VOLT_ACT: assert property (!st.tc_en |=> charge_voltage_active == $past(st.float_v))
    else $error("voltage not from float code");
  AST_PAUSE: assert property (st.pause && !cfg_wr |-> charge_paused ##1 !st.eq_req)
    else $error("pause not honoured");
  AST_RESET: assert property (@(posedge clock) disable iff (1'b0) !resetn |=>
      st.iin_cap == `CCR_RST_IIN_CAP && st.taper == `CCR_RST_TAPER && st.tc_en)
    else $error("defaults not loaded");
endmodule

// ===== ccr_host_model.sv
`timescale 1ns/10ps
module ccr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Clock
  input wire logic clock,
  // Bus pins
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  logic ok;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    ok = 1'b1;
  end
  task automatic step();
    repeat (8) @(posedge clock);
  endtask
  // Data moves only while the clock line is low
  task automatic xfer(input logic b, output logic r);
    sda_rel <= b;
    step();
    scl <= 1'b1;
    step();
    r = sda;
    scl <= 1'b0;
    step();
  endtask
  task automatic start();
    sda_rel <= 1'b1;
    step();
    scl <= 1'b1;
    step();
    sda_rel <= 1'b0;
    step();
    scl <= 1'b0;
    step();
  endtask
  task automatic stop();
    sda_rel <= 1'b0;
    step();
    scl <= 1'b1;
    step();
    sda_rel <= 1'b1;
    step();
  endtask
  // Ninth bit must be pulled low by the device
  task automatic put_byte(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(v[i], r);
    end
    xfer(1'b1, r);
    if (r !== 1'b0) begin
      ok = 1'b0;
    end
  endtask
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      v[i] = r;
    end
    xfer(last, r);
  endtask
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d);
    ok = 1'b1;
    start();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(cmd);
    put_byte(d[7:0]);
    put_byte(d[15:8]);
    stop();
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
    ok = 1'b1;
    start();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(cmd);
    start();
    put_byte({DEV_ADDR, 1'b1});
    get_byte(1'b0, d[7:0]);
    get_byte(1'b1, d[15:8]);
    stop();
  endtask
endmodule

// ===== charger_config_register_bank_tb_top.sv
`timescale 1ns/10ps
`include "ccr_defines.svh"
module charger_config_register_bank_tb_top;
  localparam logic [7:0] CMDS [8] = '{8'h14, 8'h15, 8'h16, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h29};
  localparam logic [15:0] RSTV [8] = '{16'h0000, 16'h003F, 16'h001F, 16'h0000, 16'h001F,
    16'h0015, 16'h0888, 16'h0002};
  localparam logic [15:0] MSKV [8] = '{16'h002E, 16'h003F, 16'h00FF, 16'hFFFF, 16'h001F,
    16'h003F, 16'hFFFF, 16'h0002};
  logic clock, resetn, scl, sda_rel, sda_out, sda_oe_n;
  logic charging, input_present, in_absorb, absorb_timer_done, equalize_timer_done;
  logic thermal_reg_active, vin_below_1v;
  logic [15:0] ibat_reading, rd;
  logic [4:0] thermal_cap_code, charge_current_active;
  logic [5:0] temp_comp_code, iin_cap_active, charge_voltage_active;
  logic [7:0] ppt_droop_code, droop_active;
  logic meas_tick, telemetry_on, meas_fast, equalize_active, equalize_pending;
  logic storage_mode, charge_paused, taper_detect;
  int n_errors = 0;
  int checks = 0;
  int n;
  // Pulled-up open-drain data line
  wire logic sda = sda_rel & (sda_oe_n | sda_out);
  ccr_config_bank #(.FAST_CYCLES(8), .SLOW_CYCLES(32)) u_dut (.clock(clock), .resetn(resetn),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .charging(charging), .input_present(input_present), .in_absorb(in_absorb),
    .absorb_timer_done(absorb_timer_done), .equalize_timer_done(equalize_timer_done),
    .ibat_reading(ibat_reading), .thermal_reg_active(thermal_reg_active),
    .thermal_cap_code(thermal_cap_code), .temp_comp_code(temp_comp_code),
    .ppt_droop_code(ppt_droop_code), .vin_below_1v(vin_below_1v),
    .iin_cap_active(iin_cap_active), .droop_active(droop_active),
    .charge_current_active(charge_current_active),
    .charge_voltage_active(charge_voltage_active), .meas_tick(meas_tick),
    .telemetry_on(telemetry_on), .meas_fast(meas_fast), .equalize_active(equalize_active),
    .equalize_pending(equalize_pending), .storage_mode(storage_mode),
    .charge_paused(charge_paused), .taper_detect(taper_detect));
  ccr_host_model u_host (.clock(clock), .scl(scl), .sda_rel(sda_rel), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.write_word(c, d);
    check({15'h0, u_host.ok}, 16'h0001);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    u_host.read_word(c, rd);
    check({15'h0, u_host.ok}, 16'h0001);
    check(rd, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge clock);
  endtask
  task automatic count_ticks();
    n = 0;
    repeat (64) begin
      @(posedge clock);
      if (meas_tick === 1'b1) n++;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {resetn, charging, input_present, in_absorb, absorb_timer_done} = '0;
    {equalize_timer_done, thermal_reg_active, vin_below_1v} = '0;
    ibat_reading = 16'h1000;
    thermal_cap_code = 5'h05;
    temp_comp_code = 6'h2A;
    ppt_droop_code = 8'h77;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    check({2'h0, iin_cap_active, droop_active}, 16'h3F1F);
    check({11'h0, charge_current_active}, 16'h001F);
    check({10'h0, charge_voltage_active}, 16'h002A);
    for (int i = 0; i < 8; i++) begin
      rd_chk(CMDS[i], RSTV[i]);
    end
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      wr(CMDS[i], 16'hFFFF);
      rd_chk(CMDS[i], MSKV[i]);
    end
    u_host.write_word(8'h20, 16'hFFFF);
    u_host.read_word(8'h20, rd);
    check(rd, 16'h0000);
    check({2'h0, iin_cap_active, droop_active}, 16'h3F77);
    check({charge_paused, meas_fast, telemetry_on}, 3'h7);
    wr(8'h14, 16'h0000);
    settle();
    check({8'h0, droop_active}, 16'h00FF);
    wr(8'h29, 16'h0000);
    check({10'h0, charge_voltage_active}, 16'h003F);
    wr(8'h1B, 16'h0015);
    check({10'h0, charge_voltage_active}, 16'h0015);
    $display("test fields done");
    @(posedge clock);
    thermal_reg_active <= 1'b1;
    settle();
    check({11'h0, charge_current_active}, 16'h0005);
    wr(8'h1A, 16'h0003);
    check({11'h0, charge_current_active}, 16'h0003);
    wr(8'h1A, 16'h0010);
    @(posedge clock);
    thermal_reg_active <= 1'b0;
    settle();
    check({11'h0, charge_current_active}, 16'h0010);
    $display("test current done");
    @(posedge clock);
    input_present <= 1'b1;
    wr(8'h14, 16'h0008);
    count_ticks();
    check(16'(n), 16'h0008);
    wr(8'h14, 16'h0000);
    count_ticks();
    check(16'(n), 16'h0002);
    @(posedge clock);
    charging <= 1'b1;
    count_ticks();
    check(16'(n), 16'h0008);
    @(posedge clock);
    {charging, input_present} <= 2'b00;
    settle();
    check({15'h0, telemetry_on}, 16'h0000);
    wr(8'h14, 16'h0004);
    check({15'h0, telemetry_on}, 16'h0001);
    $display("test telemetry done");
    wr(8'h1C, 16'h0888);
    check({15'h0, taper_detect}, 16'h0000);
    @(posedge clock);
    ibat_reading <= 16'h0100;
    settle();
    check({15'h0, taper_detect}, 16'h0001);
    wr(8'h1C, 16'hFF00);
    check({15'h0, taper_detect}, 16'h0000);
    wr(8'h1C, 16'h0888);
    @(posedge clock);
    ibat_reading <= 16'h1000;
    wr(8'h14, 16'h0001);
    check({equalize_pending, equalize_active}, 2'h2);
    @(posedge clock);
    {in_absorb, absorb_timer_done} <= 2'b11;
    settle();
    check({equalize_pending, equalize_active}, 2'h1);
    @(posedge clock);
    {in_absorb, absorb_timer_done, equalize_timer_done} <= 3'b001;
    settle();
    check({equalize_pending, equalize_active}, 2'h0);
    @(posedge clock);
    equalize_timer_done <= 1'b0;
    rd_chk(8'h14, 16'h0000);
    wr(8'h14, 16'h0001);
    @(posedge clock);
    {in_absorb, ibat_reading} <= {1'b1, 16'h0100};
    settle();
    check({equalize_pending, equalize_active}, 2'h1);
    @(posedge clock);
    {in_absorb, ibat_reading} <= {1'b0, 16'h1000};
    wr(8'h14, 16'h0000);
    check({equalize_pending, equalize_active}, 2'h0);
    wr(8'h14, 16'h0001);
    wr(8'h14, 16'h0021);
    rd_chk(8'h14, 16'h0020);
    check({equalize_pending, charge_paused}, 2'h1);
    $display("test equalize done");
    wr(8'h19, 16'h534D);
    check({15'h0, storage_mode}, 16'h0000);
    @(posedge clock);
    vin_below_1v <= 1'b1;
    settle();
    check({15'h0, storage_mode}, 16'h0001);
    wr(8'h19, 16'h534C);
    check({15'h0, storage_mode}, 16'h0000);
    $display("test storage done");
    report_and_stop();
  end
endmodule
